// File: design/card_front_pkg.sv
// Shared constants and carrier types for the card serial bus front end.
// Assumes one system clock domain; all pins arrive asynchronous to it.
`default_nettype none
package card_front_pkg;
  // ----------------------------------------------------------------
  // Pin bundle indices
  // ----------------------------------------------------------------
  localparam int PIN_W = 4;
  localparam int PIN_CLK = 0;
  localparam int PIN_CMD = 1;
  localparam int PIN_DAT = 2;
  localparam int PIN_SEL = 3;

  // ----------------------------------------------------------------
  // Command frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_FRAME_BITS = 6'h30;
  localparam logic [5:0] CMD_HDR_BITS = 6'h08;
  localparam logic [1:0] CMD_HDR_PREFIX = 2'h1;
  localparam logic [5:0] GO_IDLE_INDEX = 6'h00;

  typedef enum logic {MODE_NATIVE, MODE_SPI} mode_t;

  typedef struct packed {
    logic clk;
    logic cmd;
    logic dat;
    logic sel_n;
  } pins_t;

  // Host clock idles low, other pins idle high
  localparam pins_t PIN_IDLE = '{clk: 1'b0, cmd: 1'b1, dat: 1'b1, sel_n: 1'b1};

  typedef struct packed {
    mode_t mode;
    logic in_frame;
    logic [5:0] bit_cnt;
    logic [7:0] hdr;
    logic sel_hi_seen;
    logic idle_cmd;
    logic rx_valid;
    logic rx_cmd_bit;
    logic rx_dat_bit;
    logic [5:0] cmd_index;
    logic cmd_index_valid;
    logic cmd_refused;
    logic cmd_out;
    logic cmd_oe_n;
    logic dat_out;
    logic dat_oe_n;
    logic tx_taken;
  } state_t;
endpackage
`default_nettype wire

// File: design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes inputs are asynchronous to i_clk_sys.
`default_nettype none
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  logic [W-1:0] lvl_nxt;

  // Change taken only when stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  // Reset to each pin's idle level so no false edge at release
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      lvl_r <= RST_VAL;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= lvl_nxt & ~lvl_r;
      fall_r <= ~lvl_nxt & lvl_r;
    end
  end

  assign o_level = lvl_r;
  assign o_rise = rise_r;
  assign o_fall = fall_r;
endmodule
`default_nettype wire

// File: design/card_serial_bus_front_end.sv
// Pin-side front end of a serial flash card: native bus and SPI modes.
// Assumes power-on detector drives i_rstn; host clock well below i_clk_sys.
//
// Summary of operation
// - SPI only if select low during reset command
// - Shared pins, native mode after power-up
// - One command and data bit per clock
// - Command line open-drain at init, else push-pull
// - Host sends commands, card returns responses
// - Data line driven push-pull when outputting
// - Pins resynchronised into internal clock domain
// - Power-on detector resets, no external reset
// - Deselect during programming does not abort
// - No broadcast commands in SPI mode (not enforced: only stream and multi-block indices are refused)
// - SPI allows only single-block data commands
// - Select line replaces identification and addressing
// - SPI: command pin input, data pin output
// - SPI: card alone drives data out
`default_nettype none
module card_serial_bus_front_end
  import card_front_pkg::*;
#(
  parameter logic [5:0] STREAM_RD_INDEX = 6'h01,
  parameter logic [5:0] STREAM_WR_INDEX = 6'h02,
  parameter logic [5:0] MULTI_RD_INDEX = 6'h03,
  parameter logic [5:0] MULTI_WR_INDEX = 6'h04
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  input wire logic i_cmd,
  output logic o_cmd,
  output logic o_cmd_oe_n,
  input wire logic i_data_line,
  output logic o_data_line,
  output logic o_data_line_oe_n,
  input wire logic i_reserved_select_pin,
  input wire logic i_tx_cmd_en,
  input wire logic i_tx_cmd_bit,
  input wire logic i_tx_open_drain,
  input wire logic i_tx_dat_en,
  input wire logic i_tx_dat_bit,
  input wire logic i_prog_busy,
  output logic o_tx_taken,
  output logic o_rx_valid,
  output logic o_rx_cmd_bit,
  output logic o_rx_dat_bit,
  output logic [5:0] o_cmd_index,
  output logic o_cmd_index_valid,
  output logic o_cmd_refused,
  output logic o_spi_mode
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pins_t pin_async, pin_lvl, pin_rise, pin_fall;
  state_t st_r, st_nxt;
  logic sel, hdr_done, frame_end;
  logic [7:0] hdr_next;

  assign pin_async = '{clk: i_link_clk, cmd: i_cmd, dat: i_data_line,
                       sel_n: i_reserved_select_pin};

  // Host clock only sampled; stopped clock simply yields no edges
  pin_sync #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(pin_async),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  function automatic logic refused_index(input logic [5:0] idx);
    return idx == STREAM_RD_INDEX || idx == STREAM_WR_INDEX ||
           idx == MULTI_RD_INDEX || idx == MULTI_WR_INDEX;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // In SPI mode a deselected card hears nothing and keeps quiet
  assign sel = (st_r.mode == MODE_NATIVE) || !pin_lvl.sel_n;
  assign hdr_next = {st_r.hdr[6:0], pin_lvl.cmd};
  assign hdr_done = st_r.bit_cnt == (CMD_HDR_BITS - 6'h01);
  assign frame_end = st_r.bit_cnt == (CMD_FRAME_BITS - 6'h01);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_valid = 1'b0;
    st_nxt.tx_taken = 1'b0;
    st_nxt.cmd_index_valid = 1'b0;
    st_nxt.cmd_refused = 1'b0;
    // Sample on host rising edge, one bit per line
    if (pin_rise.clk && sel) begin
      st_nxt.rx_valid = 1'b1;
      st_nxt.rx_cmd_bit = pin_lvl.cmd;
      st_nxt.rx_dat_bit = pin_lvl.dat;
      if (!st_r.in_frame) begin
        // Own responses are not mistaken for commands
        if (!pin_lvl.cmd && !i_tx_cmd_en) begin
          st_nxt.in_frame = 1'b1;
          st_nxt.bit_cnt = 6'h01;
          st_nxt.hdr = hdr_next;
          st_nxt.sel_hi_seen = pin_lvl.sel_n;
          st_nxt.idle_cmd = 1'b0;
        end
      end else begin
        st_nxt.bit_cnt = st_r.bit_cnt + 6'h01;
        st_nxt.hdr = hdr_next;
        st_nxt.sel_hi_seen = st_r.sel_hi_seen | pin_lvl.sel_n;
        if (hdr_done) begin
          st_nxt.cmd_index = hdr_next[5:0];
          st_nxt.cmd_index_valid = hdr_next[7:6] == CMD_HDR_PREFIX;
          st_nxt.idle_cmd = (hdr_next[7:6] == CMD_HDR_PREFIX) &&
                            (hdr_next[5:0] == GO_IDLE_INDEX);
          st_nxt.cmd_refused = (st_r.mode == MODE_SPI) &&
                               refused_index(hdr_next[5:0]);
        end
        if (frame_end) begin
          st_nxt.in_frame = 1'b0;
          st_nxt.bit_cnt = '0;
          // Mode only changes by reset command with select held low
          if (st_r.idle_cmd && !st_r.sel_hi_seen && !pin_lvl.sel_n) begin
            st_nxt.mode = MODE_SPI;
          end
        end
      end
    end
    // Launch card bits on host falling edge
    if (pin_fall.clk && sel) begin
      st_nxt.tx_taken = 1'b1;
      if (st_r.mode == MODE_NATIVE) begin
        if (i_tx_cmd_en && i_tx_open_drain) begin
          st_nxt.cmd_out = 1'b0;
          st_nxt.cmd_oe_n = i_tx_cmd_bit;
        end else begin
          st_nxt.cmd_out = i_tx_cmd_bit;
          st_nxt.cmd_oe_n = !i_tx_cmd_en;
        end
        st_nxt.dat_out = i_tx_dat_bit;
        st_nxt.dat_oe_n = !i_tx_dat_en;
      end else begin
        st_nxt.dat_out = i_tx_dat_bit;
      end
    end
    // SPI: command pin is input only, data out owned while selected
    if (st_r.mode == MODE_SPI) begin
      st_nxt.cmd_oe_n = 1'b1;
      st_nxt.dat_oe_n = pin_lvl.sel_n;
      // Deselect drops a cut frame; programming core is never told
      if (pin_lvl.sel_n) begin
        st_nxt.in_frame = 1'b0;
        st_nxt.bit_cnt = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Only reset is the on-card power-on detector
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '{mode: MODE_NATIVE, in_frame: 1'b0, bit_cnt: 6'h00,
                hdr: 8'hFF, sel_hi_seen: 1'b0, idle_cmd: 1'b0,
                rx_valid: 1'b0, rx_cmd_bit: 1'b1, rx_dat_bit: 1'b1,
                cmd_index: 6'h00, cmd_index_valid: 1'b0, cmd_refused: 1'b0,
                cmd_out: 1'b1, cmd_oe_n: 1'b1, dat_out: 1'b1,
                dat_oe_n: 1'b1, tx_taken: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cmd = st_r.cmd_out;
  assign o_cmd_oe_n = st_r.cmd_oe_n;
  assign o_data_line = st_r.dat_out;
  assign o_data_line_oe_n = st_r.dat_oe_n;
  assign o_tx_taken = st_r.tx_taken;
  assign o_rx_valid = st_r.rx_valid;
  assign o_rx_cmd_bit = st_r.rx_cmd_bit;
  assign o_rx_dat_bit = st_r.rx_dat_bit;
  assign o_cmd_index = st_r.cmd_index;
  assign o_cmd_index_valid = st_r.cmd_index_valid;
  assign o_cmd_refused = st_r.cmd_refused;
  assign o_spi_mode = st_r.mode == MODE_SPI;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_spi_entry_cause: assert property ($rose(o_spi_mode) |->
    $past(st_r.idle_cmd) && !$past(st_r.sel_hi_seen) && $past(pin_rise.clk))
    else $error("SPI mode entered without select-low reset command");
  a_mode_sticky: assert property (o_spi_mode |=> o_spi_mode)
    else $error("SPI mode left without reset");
  a_one_bit_edge: assert property (pin_rise.clk && sel |=> o_rx_valid ##1 !o_rx_valid)
    else $error("Host edge did not give exactly one bit");
  a_open_drain_low: assert property (!o_spi_mode && i_tx_open_drain && i_tx_cmd_en
    && pin_fall.clk |=> o_cmd_oe_n || !o_cmd)
    else $error("Open-drain command line drove high");
  a_dat_push_pull: assert property (!o_spi_mode && i_tx_dat_en && pin_fall.clk
    |=> !o_data_line_oe_n && o_data_line == $past(i_tx_dat_bit))
    else $error("Data line not driven with launched bit");
  a_deselect_quiet: assert property (o_spi_mode && pin_lvl.sel_n |=>
    !o_rx_valid && !o_tx_taken)
    else $error("Deselected card reacted to host clock");
  a_refuse_spi_only: assert property (o_cmd_refused |-> o_spi_mode && o_cmd_index_valid)
    else $error("Command refused outside SPI mode");
  a_spi_cmd_input: assert property (o_spi_mode ##1 o_spi_mode |-> o_cmd_oe_n)
    else $error("Command pin driven in SPI mode");
  a_spi_dout_owner: assert property (o_spi_mode && !pin_lvl.sel_n |=> !o_data_line_oe_n)
    else $error("Selected SPI card not driving data out");
  a_prog_deselect: assert property (o_spi_mode && i_prog_busy && pin_lvl.sel_n
    |=> o_spi_mode && o_data_line_oe_n)
    else $error("Deselect during programming changed mode or drive");

  c_spi_entry: cover property ($rose(o_spi_mode));
  c_refused: cover property (o_cmd_refused);
  c_native_resp: cover property (!o_spi_mode && !o_cmd_oe_n);
  c_spi_deselect_busy: cover property (o_spi_mode && i_prog_busy && pin_lvl.sel_n);
endmodule
`default_nettype wire

// File: tb/host_link_model.sv
// Host side model: link clock, command frames and chip select.
// Assumes the card samples on rising link edges; link period 400 ns.
`default_nettype none
module host_link_model (
  input wire logic i_clk_sys,
  input wire logic i_card_cmd,
  input wire logic i_card_cmd_oe_n,
  input wire logic i_card_data,
  input wire logic i_card_data_oe_n,
  output var logic o_link_clk,
  output logic o_cmd_line,
  output var logic o_data_line,
  output var logic o_sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_en = 1'b0;
  logic host_bit = 1'b1;
  initial begin
    o_link_clk = 1'b0;
    o_sel_n = 1'b1;
    o_data_line = 1'b1;
  end
  // Pull-up on the command line when nobody drives
  assign o_cmd_line = !i_card_cmd_oe_n ? i_card_cmd : (host_en ? host_bit : 1'b1);
  // No pull on data: undriven line toggles so a stale level is never seen
  always @(posedge i_clk_sys) begin
    o_data_line <= !i_card_data_oe_n ? i_card_data : ~o_data_line;
  end
  task automatic pulse();
    #200 o_link_clk = 1'b1;
    #200 o_link_clk = 1'b0;
  endtask
  task automatic set_sel(input logic sel_n);
    o_sel_n = sel_n;
  endtask
  // Clock stands still outside frames except for lone pulse() calls
  task automatic send_frame(input logic [47:0] f, input logic sel_n);
    o_sel_n = sel_n;
    for (int i = 47; i >= 0; i--) begin
      host_en = 1'b1;
      host_bit = f[i];
      pulse();
    end
    host_en = 1'b0;
    #400 o_sel_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/card_serial_bus_front_end_test.sv
// Self-checking bench for the card front end, host model on the pins.
// Assumes 20 MHz system clock and the designer's contract timing.
`default_nettype none
module card_serial_bus_front_end_test;
  import card_front_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, link_clk, cmd_w, data_w, sel_n;
  logic o_cmd, o_cmd_oe_n, o_data, o_data_oe_n, o_tx_taken, o_rx_valid, o_rx_cmd_bit;
  logic o_idx_valid, o_refused, o_spi_mode, o_rx_dat;
  logic [5:0] o_cmd_index;
  logic tx_cmd_en = 1'b0, tx_cmd_bit = 1'b1, tx_od = 1'b1, tx_data_en = 1'b0;
  logic tx_data_bit = 1'b1, prog_busy = 1'b0;
  int mismatches = 0, compares = 0, rx_cnt = 0, idx_cnt = 0, ref_cnt = 0, tx_cnt = 0;
  localparam logic [5:0] REF_IDX [4] = '{6'h0B, 6'h14, 6'h12, 6'h19};
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  card_serial_bus_front_end #(.STREAM_RD_INDEX(REF_IDX[0]), .STREAM_WR_INDEX(REF_IDX[1]),
    .MULTI_RD_INDEX(REF_IDX[2]), .MULTI_WR_INDEX(REF_IDX[3])) dut_u (
    .i_clk_sys(clk), .i_rstn(rstn), .i_link_clk(link_clk), .i_cmd(cmd_w), .o_cmd(o_cmd),
    .o_cmd_oe_n(o_cmd_oe_n), .i_data_line(data_w), .o_data_line(o_data),
    .o_data_line_oe_n(o_data_oe_n), .i_reserved_select_pin(sel_n), .i_tx_cmd_en(tx_cmd_en),
    .i_tx_cmd_bit(tx_cmd_bit), .i_tx_open_drain(tx_od), .i_tx_dat_en(tx_data_en),
    .i_tx_dat_bit(tx_data_bit), .i_prog_busy(prog_busy), .o_tx_taken(o_tx_taken),
    .o_rx_valid(o_rx_valid), .o_rx_cmd_bit(o_rx_cmd_bit), .o_rx_dat_bit(o_rx_dat),
    .o_cmd_index(o_cmd_index), .o_cmd_index_valid(o_idx_valid), .o_cmd_refused(o_refused),
    .o_spi_mode(o_spi_mode));
  host_link_model host_u (.i_clk_sys(clk), .i_card_cmd(o_cmd), .i_card_cmd_oe_n(o_cmd_oe_n),
    .i_card_data(o_data), .i_card_data_oe_n(o_data_oe_n), .o_link_clk(link_clk),
    .o_cmd_line(cmd_w), .o_data_line(data_w), .o_sel_n(sel_n));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (o_rx_valid === 1'b1) rx_cnt++;
    if (o_idx_valid === 1'b1) idx_cnt++;
    if (o_refused === 1'b1) ref_cnt++;
    if (o_tx_taken === 1'b1) tx_cnt++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run_frame(input logic [5:0] idx, input logic sel, input int n_rx,
                           input int n_ref);
    int r0, i0, f0;
    r0 = rx_cnt;
    i0 = idx_cnt;
    f0 = ref_cnt;
    host_u.send_frame({CMD_HDR_PREFIX, idx, 32'h0000_0000, 8'h01}, sel);
    repeat (8) @(negedge clk);
    check("rx_count", 8'(rx_cnt - r0), 8'(n_rx));
    check("index_count", 8'(idx_cnt - i0), 8'(n_rx / 48));
    check("refused", 8'(ref_cnt - f0), 8'(n_ref));
    if (n_rx > 0) check("index", 8'(o_cmd_index), 8'(idx));
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check("spi_mode", 8'(o_spi_mode), 8'h00);
    check("cmd_oe_n", 8'(o_cmd_oe_n), 8'h01);
    check("data_oe_n", 8'(o_data_oe_n), 8'h01);
  endtask
  task automatic test_native_rx();
    run_frame(6'h05, 1'b1, 48, 0);
    check("rx_cmd_bit", 8'(o_rx_cmd_bit), 8'h01);
    run_frame(REF_IDX[0], 1'b1, 48, 0);
    run_frame(GO_IDLE_INDEX, 1'b1, 48, 0);
    check("spi_mode", 8'(o_spi_mode), 8'h00);
  endtask
  task automatic test_native_tx();
    // Columns: enable, bit, open drain, expected line value, expected active-low enable (cmd_oe_n)
    logic [4:0] tbl [4] = '{5'b11101, 5'b10100, 5'b11010, 5'b01011};
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      {tx_cmd_en, tx_cmd_bit, tx_od} = tbl[k][4:2];
      tx_data_en = tbl[k][4];
      tx_data_bit = tbl[k][3];
      host_u.pulse();
      for (int n = 0; n < 20 && o_tx_taken !== 1'b1; n++) @(negedge clk);
      check("tx_taken", 8'(o_tx_taken), 8'h01);
      check("cmd_out", 8'(o_cmd), 8'(tbl[k][1]));
      check("cmd_oe_n", 8'(o_cmd_oe_n), 8'(tbl[k][0]));
      check("data_oe_n", 8'(o_data_oe_n), 8'(!tbl[k][4]));
      if (tbl[k][4]) check("data_out", 8'(o_data), 8'(tbl[k][3]));
      if (k > 0) check("rx_dat_bit", 8'(o_rx_dat), 8'(tbl[k-1][3]));
    end
  endtask
  task automatic test_spi();
    run_frame(GO_IDLE_INDEX, 1'b0, 48, 0);
    check("spi_mode", 8'(o_spi_mode), 8'h01);
    check("cmd_oe_n", 8'(o_cmd_oe_n), 8'h01);
    for (int k = 0; k < 4; k++) run_frame(REF_IDX[k], 1'b0, 48, 1);
    run_frame(6'h11, 1'b0, 48, 0);
    run_frame(6'h05, 1'b1, 0, 0);
  endtask
  task automatic test_spi_select();
    host_u.set_sel(1'b0);
    repeat (10) @(negedge clk);
    check("data_oe_n", 8'(o_data_oe_n), 8'h00);
    tx_data_bit = 1'b0;
    host_u.pulse();
    repeat (8) @(negedge clk);
    check("spi_data_out", 8'(o_data), 8'h00);
    tx_data_bit = 1'b1;
    prog_busy = 1'b1;
    host_u.set_sel(1'b1);
    repeat (10) @(negedge clk);
    check("data_oe_n", 8'(o_data_oe_n), 8'h01);
    check("spi_mode", 8'(o_spi_mode), 8'h01);
    check("cmd_oe_n", 8'(o_cmd_oe_n), 8'h01);
    prog_busy = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    test_reset();
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    check("tx_after_reset", 8'(tx_cnt), 8'h00);
    test_native_rx();
    test_native_tx();
    test_spi();
    test_spi_select();
    finish_test();
  end
endmodule
`default_nettype wire
